// [rtl/tsp_pkg.sv]
// package: command codes, addresses, timing and carrier types of the serial command port
package tsp_pkg;

    // command byte set, common to both serial ports
    localparam logic [7:0] CMD_RESET = 8'h1E;
    localparam logic [7:0] CMD_CONVERT = 8'h48;
    localparam logic [7:0] CMD_READ_RESULT = 8'h00;
    localparam logic [7:0] CMD_PROM_BASE = 8'hA0;
    localparam logic [7:0] CMD_PROM_MASK = 8'hF1;
    localparam int PROM_ADDR_LSB = 1;
    localparam int PROM_ADDR_W = 3;

    // prom layout
    localparam int PROM_DEPTH = 8;
    localparam int PROM_SN_HI = 6;
    localparam int PROM_SN_LO = 7;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int RESULT_W = 24;
    localparam int SN_W = 24;

    // two-wire slave addresses, selected by the address pin level
    localparam logic [6:0] I2C_ADDR_PIN_HIGH = 7'h76;
    localparam logic [6:0] I2C_ADDR_PIN_LOW = 7'h77;
    localparam logic [3:0] I2C_LAST_BIT = 4'h7;
    localparam logic [3:0] I2C_BYTE_BITS = 4'h8;
    localparam logic [2:0] I2C_BYTE_CAP = 3'h7;

    // four-wire link bit counter
    localparam logic [5:0] SPI_CMD_LAST = 6'h07;
    localparam logic [5:0] SPI_CMD_BITS = 6'h08;
    localparam logic [5:0] SPI_CNT_MAX = 6'h3F;

    // conversion timing
    localparam int REF_CLK_PERIOD_NS = 20;
    localparam int CONV_TIME_NS = 8_220_000;
    localparam int CONV_CYCLES_DFLT = CONV_TIME_NS / REF_CLK_PERIOD_NS;
    localparam int CONV_CNT_W = 20;

    typedef logic [PROM_DEPTH-1:0][WORD_W-1:0] tsp_prom_t;

    typedef enum logic [1:0] {RM_NONE, RM_RESULT, RM_PROM} tsp_rmode_e;

    typedef enum logic [2:0] {I_IDLE, I_ADDR, I_ACK, I_CMD, I_SEND, I_MACK} tsp_i2c_e;

    // command event from the four-wire link domain
    typedef struct packed {
        logic tog;
        logic seen;
        logic [7:0] code;
    } tsp_spi_evt_s;

    // result word offered to the four-wire link domain
    typedef struct packed {
        logic ready;
        logic [RESULT_W-1:0] word;
    } tsp_result_s;

    // link-side shifter, cleared whenever chip select is high
    typedef struct packed {
        logic [5:0] cnt;
        logic [6:0] rx;
        logic [RESULT_W-1:0] tx;
    } tsp_spi_s;

    // link-side event and ready synchroniser, cleared only by reset
    typedef struct packed {
        tsp_spi_evt_s evt;
        logic rdy_meta;
        logic rdy;
    } tsp_spi_side_s;

    // core state on the reference clock
    typedef struct packed {
        logic strap_meta;
        logic strap;
        logic csb_meta;
        logic select_or_address_pin;
        logic scl_meta;
        logic scl;
        logic scl_d;
        logic sda_meta;
        logic sda;
        logic sda_d;
        logic tog_meta;
        logic tog;
        logic tog_d;
        logic busy;
        logic ready;
        logic [CONV_CNT_W-1:0] conv_cnt;
        logic [RESULT_W-1:0] result;
        tsp_rmode_e rmode;
        logic [RESULT_W-1:0] rd_word;
        tsp_i2c_e ist;
        tsp_i2c_e after;
        logic [3:0] bit_cnt;
        logic [7:0] sh;
        logic [2:0] byte_cnt;
        logic sda_oe;
    } tsp_core_s;

    // value that brings the byte sum of an image to zero
    function automatic logic [7:0] tsp_check_byte(input tsp_prom_t img);
        logic [7:0] acc;
        acc = 8'h00;
        for (int i = 0; i < PROM_DEPTH; i++) begin
            acc = acc + img[i][15:8] + img[i][7:0];
        end
        return 8'h00 - acc;
    endfunction

endpackage

// [rtl/tsp_spi_link.sv]
// four-wire slave shifter running on the link clock
`timescale 1ns/100ps
`default_nettype none
module tsp_spi_link
    import tsp_pkg::*;
(
    // link clock and resets
    input wire logic sclk,
    input wire logic rst,
    input wire logic cs_n,
    // serial data
    input wire logic mosi,
    output logic miso,
    output logic shifting,
    // crossing to and from the core
    input wire tsp_result_s result,
    input wire tsp_prom_t prom,
    output tsp_spi_evt_s evt
);
    tsp_spi_s link, next_link;
    tsp_spi_side_s side, next_side;
    logic link_rst;
    logic [7:0] code_in;
    logic is_prom;

    // chip select high ends the transaction and clears the shifter
    assign link_rst = rst | cs_n;
    assign code_in = {link.rx, mosi};
    assign is_prom = (code_in & CMD_PROM_MASK) == CMD_PROM_BASE;

    // receive command bits, then load and shift the answer msb first
    always_comb begin
        next_link = link;
        if (link.cnt != SPI_CNT_MAX) begin
            next_link.cnt = link.cnt + 6'h01;
        end
        if (link.cnt < SPI_CMD_BITS) begin
            next_link.rx = code_in[6:0];
        end
        if (link.cnt == SPI_CMD_LAST) begin
            if (code_in == CMD_READ_RESULT) begin
                next_link.tx = side.rdy ? result.word : '0;
            end else if (is_prom) begin
                next_link.tx = {prom[code_in[PROM_ADDR_LSB +: PROM_ADDR_W]], 8'h00};
            end else begin
                next_link.tx = '0;
            end
        end else if (link.cnt >= SPI_CMD_BITS) begin
            next_link.tx = {link.tx[RESULT_W-2:0], 1'b0};
        end
    end

    always_ff @(posedge sclk or posedge link_rst) begin
        if (link_rst) begin
            link <= '0;
        end else begin
            link <= next_link;
        end
    end

    // command toggle toward the core and ready synchroniser from it
    always_comb begin
        next_side = side;
        next_side.rdy_meta = result.ready;
        next_side.rdy = side.rdy_meta;
        if (link.cnt == SPI_CMD_LAST) begin
            next_side.evt.tog = ~side.evt.tog;
            next_side.evt.code = code_in;
            next_side.evt.seen = side.rdy;
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            side <= '0;
        end else begin
            side <= next_side;
        end
    end

    // data changes after each rising edge, sampled on the next one
    assign miso = link.tx[RESULT_W-1];
    assign shifting = link.cnt >= SPI_CMD_BITS;
    assign evt = side.evt;

    AST_SPI_SHIFT: assert property (@(posedge sclk) disable iff (link_rst)
        (link.cnt >= SPI_CMD_BITS) |=> (link.tx == {$past(link.tx[RESULT_W-2:0]), 1'b0}))
        else $error("answer did not shift msb first");

    AST_SPI_EVENT: assert property (@(posedge sclk) disable iff (rst)
        (link.cnt == SPI_CMD_LAST) |=> (evt.code == $past(code_in)) && (evt.tog != $past(evt.tog)))
        else $error("command byte not handed to the core");

endmodule // tsp_spi_link
`default_nettype wire

// [rtl/tsp_command_port.sv]
// serial command port of the temperature sensor: protocol select, two-wire slave, core
// Overview of operation
// - strap low picks four-wire slave, strap high picks two-wire slave
// - two-wire: start, address byte, command byte, stop
// - two-wire address 1110110x when address pin high, 1110111x when low
// - four-wire transaction runs while chip select is held low
// - four-wire clock may idle low or high (modes 0 and 3)
// - one command set decoded for both ports
// - 0x1E reset, 0x48 start conversion, 0x00 read result
// - prom read is 0xA0 plus twice the word address, eight words
// - prom words one to five hold the five 16-bit coefficients
// - word six serial high bits, word seven serial low byte and checksum
// - reset command accepted anytime, returns internal state to known values
// - prom command selects a word; four-wire returns it in the same frame, two-wire on the next read
// - conversion starts only on its command, busy until complete
// - four-wire: last command clock starts conversion, data out low while busy
// - two-wire: while busy only reset is executed
// - two-wire: acknowledge of result read means conversion finished
// - repeated or premature result read returns all zeros
`timescale 1ns/100ps
`default_nettype none
module tsp_command_port
    import tsp_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_CYCLES_DFLT,
    parameter logic [WORD_W-1:0] PROM_WORD0 = 16'h0000,
    parameter logic [WORD_W-1:0] COEFF_QUARTIC = 16'h6F1E,
    parameter logic [WORD_W-1:0] COEFF_CUBIC = 16'h615E,
    parameter logic [WORD_W-1:0] COEFF_QUADRATIC = 16'h8CB0,
    parameter logic [WORD_W-1:0] COEFF_LINEAR = 16'h8017,
    parameter logic [WORD_W-1:0] COEFF_CONSTANT = 16'h9F4D,
    parameter logic [SN_W-1:0] SERIAL_NUMBER = 24'h00_0596
) (
    // core clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // link clock: four-wire clock, also two-wire clock line
    input wire logic SERIAL_CLK,
    // strap and select pins
    input wire logic PROTOCOL_STRAP_PIN,
    input wire logic SELECT_OR_ADDRESS_PIN,
    // serial data in, open drain in two-wire mode
    input wire logic SERIAL_IN_PIN,
    output logic SERIAL_IN_PIN_O,
    output logic SERIAL_IN_PIN_OE,
    // serial data out, four-wire mode
    output logic SERIAL_OUT_PIN,
    output logic SERIAL_OUT_PIN_OE,
    // converter side
    input wire logic [RESULT_W-1:0] RAW_RESULT_WIDE,
    output logic CONV_BUSY
);
    localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CNT_W'(CONV_CYCLES - 1);
    localparam logic [CONV_CNT_W-1:0] CONV_TAKE = CONV_CNT_W'(1);

    // prom image with the checksum filled in so the byte sum is zero
    localparam tsp_prom_t PROM_RAW = {SERIAL_NUMBER[7:0], 8'h00, SERIAL_NUMBER[23:8],
        COEFF_CONSTANT, COEFF_LINEAR, COEFF_QUADRATIC, COEFF_CUBIC, COEFF_QUARTIC,
        PROM_WORD0};
    localparam tsp_prom_t PROM_IMG = {PROM_RAW[PROM_SN_LO][15:8], tsp_check_byte(PROM_RAW),
        PROM_RAW[PROM_SN_HI:0]};

    tsp_core_s core, next_core;
    tsp_spi_evt_s spi_evt;
    tsp_result_s result_x;
    logic spi_miso;
    logic spi_shift;
    logic cmd_go;
    logic [7:0] cmd_code;
    logic cmd_from_spi;
    logic scl_rise, scl_fall, i2c_start, i2c_stop;
    logic [6:0] own_addr;
    logic [7:0] tx_byte;
    logic [7:0] rx_byte;

    // four-wire side, clocked by the link clock, shifter cleared by chip select high
    tsp_spi_link u_spi (
        .sclk(SERIAL_CLK),
        .rst(RST),
        .cs_n(SELECT_OR_ADDRESS_PIN),
        .mosi(SERIAL_IN_PIN),
        .miso(spi_miso),
        .shifting(spi_shift),
        .result(result_x),
        .prom(PROM_IMG),
        .evt(spi_evt)
    );

    // result offered to the link; word only changes while ready is low
    assign result_x = '{ready: core.ready, word: core.result};

    // two-wire line events from the synchronised copies
    assign scl_rise = core.scl & ~core.scl_d;
    assign scl_fall = ~core.scl & core.scl_d;
    assign i2c_start = core.scl & core.scl_d & core.sda_d & ~core.sda;
    assign i2c_stop = core.scl & core.scl_d & ~core.sda_d & core.sda;
    assign own_addr = core.select_or_address_pin ? I2C_ADDR_PIN_HIGH : I2C_ADDR_PIN_LOW;
    assign rx_byte = {core.sh[6:0], core.sda};

    // read byte selected by position, zero past the end of the word
    always_comb begin
        unique case (core.byte_cnt)
            3'h0: tx_byte = core.rd_word[23:16];
            3'h1: tx_byte = core.rd_word[15:8];
            3'h2: tx_byte = core.rd_word[7:0];
            default: tx_byte = 8'h00;
        endcase
    end

    // synchronisers, two-wire engine, command execution and conversion timer
    always_comb begin
        next_core = core;
        cmd_go = 1'b0;
        cmd_code = CMD_READ_RESULT;
        cmd_from_spi = 1'b0;
        next_core.strap_meta = PROTOCOL_STRAP_PIN;
        next_core.strap = core.strap_meta;
        next_core.csb_meta = SELECT_OR_ADDRESS_PIN;
        next_core.select_or_address_pin = core.csb_meta;
        next_core.scl_meta = SERIAL_CLK;
        next_core.scl = core.scl_meta;
        next_core.scl_d = core.scl;
        next_core.sda_meta = SERIAL_IN_PIN;
        next_core.sda = core.sda_meta;
        next_core.sda_d = core.sda;
        next_core.tog_meta = spi_evt.tog;
        next_core.tog = core.tog_meta;
        next_core.tog_d = core.tog;

        // four-wire command arrives as a toggle, code is stable by then
        if (!core.strap && (core.tog != core.tog_d)) begin
            cmd_go = 1'b1;
            cmd_code = spi_evt.code;
            cmd_from_spi = 1'b1;
        end

        // two-wire slave engine
        if (!core.strap) begin
            next_core.ist = I_IDLE;
            next_core.sda_oe = 1'b0;
        end else if (i2c_stop) begin
            next_core.ist = I_IDLE;
            next_core.sda_oe = 1'b0;
        end else if (i2c_start) begin
            next_core.ist = I_ADDR;
            next_core.bit_cnt = 4'h0;
            next_core.sda_oe = 1'b0;
        end else begin
            unique case (core.ist)
                I_IDLE: begin
                    next_core.sda_oe = 1'b0;
                end
                I_ADDR, I_CMD: begin
                    if (scl_rise) begin
                        next_core.sh = rx_byte;
                        next_core.bit_cnt = core.bit_cnt + 4'h1;
                        if (core.bit_cnt == I2C_LAST_BIT) begin
                            next_core.bit_cnt = 4'h0;
                            if (core.ist == I_ADDR) begin
                                if (core.sh[6:0] == own_addr) begin
                                    next_core.ist = I_ACK;
                                    next_core.after = core.sda ? I_SEND : I_CMD;
                                    next_core.byte_cnt = 3'h0;
                                end else begin
                                    next_core.ist = I_IDLE;
                                end
                            end else if (!core.busy || (rx_byte == CMD_RESET)) begin
                                cmd_go = 1'b1;
                                cmd_code = rx_byte;
                                next_core.ist = I_ACK;
                                next_core.after = I_IDLE;
                            end else begin
                                next_core.ist = I_IDLE;
                            end
                        end
                    end
                end
                I_ACK: begin
                    if (scl_fall) begin
                        if (core.bit_cnt == 4'h0) begin
                            next_core.sda_oe = 1'b1;
                            next_core.bit_cnt = 4'h1;
                        end else begin
                            next_core.sda_oe = 1'b0;
                            next_core.bit_cnt = 4'h0;
                            next_core.ist = core.after;
                            if (core.after == I_SEND) begin
                                next_core.sh = tx_byte;
                                next_core.sda_oe = ~tx_byte[7];
                            end
                        end
                    end
                end
                I_SEND: begin
                    if (scl_rise) begin
                        next_core.bit_cnt = core.bit_cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (core.bit_cnt == I2C_BYTE_BITS) begin
                            next_core.sda_oe = 1'b0;
                            next_core.bit_cnt = 4'h0;
                            next_core.ist = I_MACK;
                        end else begin
                            next_core.sh = {core.sh[6:0], 1'b0};
                            next_core.sda_oe = ~core.sh[6];
                        end
                    end
                end
                I_MACK: begin
                    if (scl_rise) begin
                        if (core.sda) begin
                            next_core.ist = I_IDLE;
                        end else begin
                            next_core.bit_cnt = 4'h1;
                            if (core.byte_cnt != I2C_BYTE_CAP) begin
                                next_core.byte_cnt = core.byte_cnt + 3'h1;
                            end
                        end
                    end else if (scl_fall && (core.bit_cnt == 4'h1)) begin
                        next_core.ist = I_SEND;
                        next_core.bit_cnt = 4'h0;
                        next_core.sh = tx_byte;
                        next_core.sda_oe = ~tx_byte[7];
                    end
                end
                default: begin
                    next_core.ist = I_IDLE;
                    next_core.sda_oe = 1'b0;
                end
            endcase
        end

        // command execution, same decode for both ports
        if (cmd_go) begin
            if (cmd_code == CMD_RESET) begin
                next_core.busy = 1'b0;
                next_core.ready = 1'b0;
                next_core.conv_cnt = '0;
                next_core.rmode = RM_NONE;
                next_core.rd_word = '0;
            end else if (cmd_code == CMD_CONVERT) begin
                if (!core.busy) begin
                    next_core.busy = 1'b1;
                    next_core.ready = 1'b0;
                    next_core.conv_cnt = CONV_LAST;
                end
            end else if (cmd_code == CMD_READ_RESULT) begin
                next_core.rmode = RM_RESULT;
                next_core.rd_word = core.ready ? core.result : '0;
                if (!cmd_from_spi || spi_evt.seen) begin
                    next_core.ready = 1'b0;
                end
            end else if ((cmd_code & CMD_PROM_MASK) == CMD_PROM_BASE) begin
                next_core.rmode = RM_PROM;
                next_core.rd_word = {PROM_IMG[cmd_code[PROM_ADDR_LSB +: PROM_ADDR_W]], 8'h00};
            end
        end

        // conversion timer; completion sets ready after the read above
        if (core.busy && !(cmd_go && (cmd_code == CMD_RESET))) begin
            if (core.conv_cnt == CONV_TAKE) begin
                next_core.result = RAW_RESULT_WIDE;
            end
            if (core.conv_cnt == '0) begin
                next_core.busy = 1'b0;
                next_core.ready = 1'b1;
            end else begin
                next_core.conv_cnt = core.conv_cnt - CONV_TAKE;
            end
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            core <= '0;
        end else begin
            core <= next_core;
        end
    end

    // pins: busy shown on data out outside the shift phase
    assign SERIAL_OUT_PIN = spi_shift ? spi_miso : ~core.busy;
    assign SERIAL_OUT_PIN_OE = ~core.strap & ~core.select_or_address_pin;
    assign SERIAL_IN_PIN_O = 1'b0;
    assign SERIAL_IN_PIN_OE = core.sda_oe;
    assign CONV_BUSY = core.busy;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    sequence s_launch;
        cmd_go && (cmd_code == CMD_CONVERT) && !core.busy;
    endsequence

    sequence s_finish;
        core.busy && (core.conv_cnt == '0) && !cmd_go;
    endsequence

    AST_PROTOCOL: assert property (core.strap |-> !SERIAL_OUT_PIN_OE && !cmd_from_spi)
        else $error("four-wire port active with strap high");

    AST_ADDR_MISS: assert property ((core.ist == I_ADDR) && scl_rise && !i2c_start
        && !i2c_stop && (core.bit_cnt == I2C_LAST_BIT) && (core.sh[6:0] != own_addr)
        |=> (core.ist == I_IDLE) && !core.sda_oe)
        else $error("foreign address was answered");

    AST_CONV_START: assert property (s_launch |=> core.busy && (core.conv_cnt == CONV_LAST))
        else $error("conversion did not start");

    AST_CONV_HOLD: assert property (s_launch ##1 !cmd_go |=> core.busy [*4])
        else $error("busy dropped early");

    AST_CONV_DONE: assert property (s_finish |=> core.ready && !core.busy
        && (core.result == $past(RAW_RESULT_WIDE, 2)))
        else $error("conversion result not captured");

    AST_RESET_CMD: assert property (cmd_go && (cmd_code == CMD_RESET)
        |=> !core.busy && !core.ready && (core.rmode == RM_NONE) && (core.rd_word == '0))
        else $error("reset command left state behind");

    AST_ZERO_READ: assert property (cmd_go && (cmd_code == CMD_READ_RESULT) && !core.ready
        |=> (core.rd_word == '0) && (core.rmode == RM_RESULT))
        else $error("stale result was returned");

    AST_PROM_WORD: assert property (cmd_go && ((cmd_code & CMD_PROM_MASK) == CMD_PROM_BASE)
        |=> core.rd_word[23:8] == PROM_IMG[$past(cmd_code[PROM_ADDR_LSB +: PROM_ADDR_W])])
        else $error("prom word mismatch");

    AST_BUSY_IGNORE: assert property (cmd_go && !cmd_from_spi && core.busy
        |-> cmd_code == CMD_RESET)
        else $error("command executed during conversion");

    AST_SDO_BUSY: assert property (!core.strap && !spi_shift && core.busy |-> !SERIAL_OUT_PIN)
        else $error("data out not low while busy");

endmodule // tsp_command_port
`default_nettype wire

// [tb/tsp_host.sv]
// four-wire and two-wire master model; its clock runs only inside frames
`timescale 1ns/100ps
`default_nettype none
module tsp_host (
    // link pins
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso,
    // two-wire data line as seen on the bus
    input wire logic sda
);
    // idle link at time zero
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b1;
    end
    // one frame: command byte msb first, then nbits of read data
    task automatic xfer(input logic [7:0] cmd, input int nbits, input logic idle,
                        output logic [23:0] rd);
        rd = 24'h00_0000;
        sclk = idle;
        #40 cs_n = 1'b0;
        for (int i = 0; i < 8 + nbits; i++) begin
            #40 sclk = 1'b0;
            mosi = (i < 8) ? cmd[7 - i] : ~mosi; // toggling filler after the command
            #40 if (i >= 8) rd = {rd[22:0], miso};
            sclk = 1'b1;
        end
        #40 sclk = idle;
        #40 cs_n = 1'b1;
        #80;
    endtask
    // two-wire bit: data set while the clock is low, line sampled while it is high
    task automatic i2c_bit(input logic b, output logic s);
        #200 mosi = b;
        #200 sclk = 1'b1;
        #200 s = sda;
        #200 sclk = 1'b0;
    endtask
    // two-wire frame: start, address, then command byte or nrd read bytes, stop
    task automatic i2c_xfer(input logic [7:0] adr, input logic [7:0] cmd, input int nrd,
                            output logic [1:0] ack_n, output logic [23:0] rd);
        logic s;
        rd = 24'h00_0000;
        mosi = 1'b1;
        #200 sclk = 1'b1;
        #200 mosi = 1'b0;
        #200 sclk = 1'b0;
        for (int i = 0; i < 9; i++) i2c_bit((i < 8) ? adr[7 - i] : 1'b1, ack_n[0]);
        for (int i = 0; i < 9 * (adr[0] ? nrd : 1); i++) begin
            if (!adr[0]) i2c_bit((i < 8) ? cmd[7 - i] : 1'b1, s);
            else if (i % 9 == 8) i2c_bit(i == 9 * nrd - 1, s);
            else i2c_bit(1'b1, s);
            if (adr[0] && (i % 9 != 8)) rd = {rd[22:0], s};
        end
        ack_n[1] = s;
        #200 mosi = 1'b0;
        #200 sclk = 1'b1;
        #200 mosi = 1'b1;
        #200;
    endtask
endmodule // tsp_host
`default_nettype wire

// [tb/tb.sv]
// bench: four-wire and two-wire prom reads, conversion, result reads and reset command
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
    $display("ERROR %0t mismatch %h vs %h", $time, (a), (b)); end end
module tb;
    import tsp_pkg::*;
    localparam tsp_prom_t EXP = {16'h9600, 16'h0005, 16'h9F4D, 16'h8017,
                                 16'h8CB0, 16'h615E, 16'h6F1E, 16'h0000};
    logic REF_CLK = 1'b0;
    logic RST = 1'b1;
    logic [RESULT_W-1:0] raw = 24'h8F_1B94;
    logic sclk, cs_n, mosi, serial_out_pin, sdo_oe, busy, sdi_o, sdi_oe, sda_line;
    logic strap = 1'b0;
    logic [23:0] rd;
    logic [7:0] sum;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    // core clock
    always #10 REF_CLK = ~REF_CLK;
    // open-drain data line with pull-up: low if either side pulls it
    assign sda_line = mosi & (sdi_oe ? sdi_o : 1'b1);
    tsp_host tsp_host_i (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(serial_out_pin), .sda(sda_line));
    tsp_command_port #(.CONV_CYCLES(2000), .PROM_WORD0(EXP[0]), .COEFF_QUARTIC(EXP[1]),
        .COEFF_CUBIC(EXP[2]), .COEFF_QUADRATIC(EXP[3]), .COEFF_LINEAR(EXP[4]),
        .COEFF_CONSTANT(EXP[5]), .SERIAL_NUMBER(24'h00_0596)) tsp_command_port_i (
        .REF_CLK(REF_CLK), .RST(RST), .SERIAL_CLK(sclk), .PROTOCOL_STRAP_PIN(strap),
        .SELECT_OR_ADDRESS_PIN(cs_n), .SERIAL_IN_PIN(sda_line), .SERIAL_IN_PIN_O(sdi_o),
        .SERIAL_IN_PIN_OE(sdi_oe), .SERIAL_OUT_PIN(serial_out_pin), .SERIAL_OUT_PIN_OE(sdo_oe),
        .RAW_RESULT_WIDE(raw), .CONV_BUSY(busy));
    // verdict and end of run
    task automatic tally_and_finish;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // all eight words, clock idle level alternating per frame
    task automatic t_prom;
        sum = 8'h00;
        for (int a = 0; a < 8; a++) begin
            tsp_host_i.xfer(CMD_PROM_BASE + 8'(2 * a), 16, a[0], rd);
            sum = sum + rd[15:8] + rd[7:0];
            if (a < 7) `CHK(rd[15:0], EXP[a])
        end
        `CHK(rd[15:8], EXP[7][15:8])
        `CHK(sum, 8'h00)
    endtask
    // premature read, conversion, read, repeat read, reset mid-conversion
    task automatic t_conv;
        tsp_host_i.xfer(CMD_READ_RESULT, 24, 1'b0, rd);
        `CHK(rd, 24'h00_0000)
        tsp_host_i.xfer(CMD_CONVERT, 0, 1'b0, rd);
        `CHK(busy, 1'b1)
        `CHK(serial_out_pin, 1'b0)
        for (int i = 0; i < 4000 && busy === 1'b1; i++) @(negedge REF_CLK);
        `CHK(busy, 1'b0)
        `CHK(serial_out_pin, 1'b1)
        tsp_host_i.xfer(CMD_READ_RESULT, 24, 1'b1, rd);
        `CHK(rd, raw)
        `CHK(16'(rd / 256), raw[23:8])
        tsp_host_i.xfer(CMD_READ_RESULT, 24, 1'b0, rd);
        `CHK(rd, 24'h00_0000)
        tsp_host_i.xfer(CMD_CONVERT, 0, 1'b1, rd);
        tsp_host_i.xfer(CMD_RESET, 0, 1'b0, rd);
        `CHK(busy, 1'b0)
        tsp_host_i.xfer(CMD_READ_RESULT, 24, 1'b0, rd);
        `CHK(rd, 24'h00_0000)
    endtask
    // two-wire: foreign address, conversion, refused read while busy, result and prom reads
    task automatic t_i2c;
        logic [1:0] a;
        strap = 1'b1;
        repeat (4) @(negedge REF_CLK);
        `CHK(sdo_oe, 1'b0)
        tsp_host_i.i2c_xfer(8'hEE, CMD_CONVERT, 0, a, rd);
        `CHK(a[0], 1'b1)
        tsp_host_i.i2c_xfer(8'hEC, CMD_CONVERT, 0, a, rd);
        `CHK(a, 2'b00)
        `CHK(busy, 1'b1)
        tsp_host_i.i2c_xfer(8'hEC, CMD_READ_RESULT, 0, a, rd);
        `CHK(a, 2'b10)
        for (int i = 0; i < 4000 && busy === 1'b1; i++) @(negedge REF_CLK);
        tsp_host_i.i2c_xfer(8'hEC, CMD_READ_RESULT, 0, a, rd);
        `CHK(a, 2'b00)
        tsp_host_i.i2c_xfer(8'hED, 8'h00, 3, a, rd);
        `CHK(a[0], 1'b0)
        `CHK(rd, raw)
        tsp_host_i.i2c_xfer(8'hEC, CMD_PROM_BASE + 8'h06, 0, a, rd);
        tsp_host_i.i2c_xfer(8'hED, 8'h00, 2, a, rd);
        `CHK(rd[15:0], EXP[3])
    endtask
    // hang guard
    always @(posedge REF_CLK) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            tally_and_finish;
        end
    end
    // main sequence
    initial begin
        repeat (8) @(negedge REF_CLK);
        RST = 1'b0;
        repeat (4) @(negedge REF_CLK);
        `CHK(sdo_oe, 1'b0)
        tsp_host_i.xfer(CMD_RESET, 0, 1'b0, rd);
        t_prom;
        t_conv;
        t_i2c;
        tally_and_finish;
    end
endmodule // tb
`default_nettype wire
